// ---- common/ccp_map.svh ----
// Register offsets, field positions, reset values and counts of the core
`ifndef CCP_MAP_SVH
`define CCP_MAP_SVH

`define CCP_ADDR_W 12
`define CCP_REG_CTRL 12'h000
`define CCP_REG_STATUS 12'h004
`define CCP_REG_SRC0 12'h008
`define CCP_REG_SRC1 12'h00c
`define CCP_REG_DST0 12'h010
`define CCP_REG_DST1 12'h014
`define CCP_REG_PART 12'h018
`define CCP_REG_PRCTL 12'h020
`define CCP_REG_SEED0 12'h024
`define CCP_REG_SEED1 12'h028
`define CCP_REG_SEED2 12'h02c
`define CCP_REG_RESULT 12'h030
`define CCP_MEM_SEL_BIT 11
`define CCP_MEM_WORDS 512

`define CCP_CTRL_EN 0
`define CCP_CTRL_START 1
`define CCP_CTRL_HWTRIG 2
`define CCP_CTRL_FUNC_LSB 4
`define CCP_FUNC_PRNG 2'h1
`define CCP_STATUS_BUSY 0
`define CCP_STATUS_DONE 1

`define CCP_CTRL_RST 4'h0
`define CCP_OFFS_RST 11'h000
`define CCP_PART_RST 9'h000
`define CCP_LIMIT_RST 32'h0000_0000
`define CCP_SEED_RST 32'h0000_0000

`define CCP_RESP_OKAY 2'h0
`define CCP_RESP_SLVERR 2'h2
`define CCP_RESP_DECERR 2'h3

`define CCP_PRNG_BITS 6'd33
`define CCP_TAPS_LONG 32'h0000_00c5
`define CCP_TAPS_MIDDLE 32'h0000_0009
`define CCP_TAPS_SHORT 32'h0000_0005
`define CCP_LEN_LONG 32
`define CCP_LEN_MIDDLE 31
`define CCP_LEN_SHORT 29

`endif

// ---- common/ccp_pkg.sv ----
// Types shared by the crypto core files
package ccp_pkg;

    typedef enum logic [4:0] {
        CCP_PM_FRESH = 5'h01,
        CCP_PM_OPEN = 5'h02,
        CCP_PM_PROTECTED = 5'h04,
        CCP_PM_KILLED = 5'h08,
        CCP_PM_BOOT = 5'h10
    } ccp_pmode_e;

    typedef enum logic [3:0] {
        CCP_IDLE = 4'h1,
        CCP_GATHER = 4'h2,
        CCP_COMPUTE = 4'h4,
        CCP_STORE = 4'h8
    } ccp_state_e;

    typedef struct packed {
        logic [10:0] source_offset_first;
        logic [10:0] source_offset_second;
        logic [10:0] dest_offset_first;
        logic [10:0] dest_offset_second;
    } ccp_opnd_s;

    typedef logic [31:0] ccp_word_t;

endpackage

// ---- hw/ccp_lfsr.sv ----
// Fibonacci shift register with fixed taps, seed load and state readback
module ccp_lfsr #(
    parameter int W = 32,
    parameter logic [31:0] TAPS = 32'h0000_00c5
) (
    // Clock and control
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic shift,
    input wire logic load,
    input wire logic [31:0] load_value,
    // State
    output logic [31:0] state,
    output logic out_bit
);
    logic [W-1:0] sreg;
    logic feedback;

    assign feedback = ^(sreg & TAPS[W-1:0]);
    assign out_bit = sreg[0];
    assign state = 32'(sreg);

    // A seed write wins over a shift in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            sreg <= '0;
        end else if (ce) begin
            if (load) begin
                sreg <= load_value[W-1:0];
            end else if (shift) begin
                sreg <= {feedback, sreg[W-1:1]};
            end
        end
    end
endmodule // ccp_lfsr

// ---- hw/ccp_core.sv ----
// Crypto core framework: bus slave, triggers, operand buffer and PRNG
//
// Behaviour
// - Only one function runs at a time; starts while busy are ignored.
// - The block is a bus slave only and never starts transfers.
// - A rising edge on the input trigger starts the configured operation.
// - Completion emits a single pulse on the output trigger.
// - The completion pulse comes for software and trigger started operations.
// - Operands live in a 2 KB buffer that keeps its contents.
// - For a cipher, first source locates the key, second the plaintext.
// - For a cipher, first destination gets last round key, second ciphertext.
// - Buffer writes by the bus are accepted while an operation runs.
// - Bus access to the buffer wins over operation access.
// - Privileged processor accesses reach every register and every buffer region.
// - User accesses reach user registers and region only, but all in fresh mode and in boot mode from the processor; debugger only fresh/open; others refused.
// - A privileged register holds the privileged/user buffer boundary.
// - Access rights follow the chip protection mode and the requester.
// - The generator yields values bounded by the upper limit field.
// - Three Fibonacci shift registers of 32, 31 and 29 bits.
// - Fixed feedback taps 32,30,26,25; 31,28; and 29,27.
// - Seed registers load a seed and read back the present state.
// - Each random bit is the XOR of the three register outputs.
// - Result is upper half of (limit+1)*pr[32:1] + limit*pr[0].
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`include "ccp_map.svh"

module ccp_core (
    // Clock, reset and clock enable
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CE,
    // AXI4-Lite write address and data
    input wire logic S_AWVALID,
    output logic S_AWREADY,
    input wire logic [11:0] S_AWADDR,
    input wire logic [2:0] S_AWPROT,
    input wire logic S_WVALID,
    output logic S_WREADY,
    input wire logic [31:0] S_WDATA,
    input wire logic [3:0] S_WSTRB,
    // AXI4-Lite write response
    output logic S_BVALID,
    input wire logic S_BREADY,
    output logic [1:0] S_BRESP,
    // AXI4-Lite read
    input wire logic S_ARVALID,
    output logic S_ARREADY,
    input wire logic [11:0] S_ARADDR,
    input wire logic [2:0] S_ARPROT,
    output logic S_RVALID,
    input wire logic S_RREADY,
    output logic [31:0] S_RDATA,
    output logic [1:0] S_RRESP,
    // Access context from the system
    input wire ccp_pkg::ccp_pmode_e PROT_MODE,
    input wire logic DEBUG_MASTER,
    // Triggers
    input wire logic TRIG_IN,
    output logic TRIG_OUT,
    // Operand offsets for the cipher and hash datapaths, and busy flag
    output ccp_pkg::ccp_opnd_s OPERANDS,
    output logic BUSY
);
    import ccp_pkg::*;

    localparam int LEN [3] = '{`CCP_LEN_LONG, `CCP_LEN_MIDDLE, `CCP_LEN_SHORT};
    localparam logic [31:0] TAP [3] =
        '{`CCP_TAPS_LONG, `CCP_TAPS_MIDDLE, `CCP_TAPS_SHORT};

    // Full rights, user rights, or none, per requester and protection mode
    function automatic logic access_ok(logic priv, logic dbg,
                                       ccp_pmode_e m, logic tgt_priv);
        logic full;
        logic user;
        full = dbg ? (m == CCP_PM_FRESH)
                   : (priv || m == CCP_PM_FRESH || m == CCP_PM_BOOT);
        user = dbg ? (m == CCP_PM_FRESH || m == CCP_PM_OPEN) : 1'b1;
        return full || (user && !tgt_priv);
    endfunction

    function automatic logic is_mapped(logic [11:0] a);
        logic hit;
        hit = a[`CCP_MEM_SEL_BIT];
        case ({a[11:2], 2'b00})
            `CCP_REG_CTRL, `CCP_REG_STATUS, `CCP_REG_SRC0, `CCP_REG_SRC1,
            `CCP_REG_DST0, `CCP_REG_DST1, `CCP_REG_PART, `CCP_REG_PRCTL,
            `CCP_REG_SEED0, `CCP_REG_SEED1, `CCP_REG_SEED2,
            `CCP_REG_RESULT: hit = 1'b1;
            default: ;
        endcase
        return hit;
    endfunction

    function automatic logic is_priv(logic [11:0] a, logic [8:0] bound);
        if (a[`CCP_MEM_SEL_BIT]) begin
            return a[10:2] < bound;
        end
        return {a[11:2], 2'b00} == `CCP_REG_PART;
    endfunction

    function automatic logic [31:0] merge(logic [31:0] old,
                                          logic [31:0] nw, logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Bus side state
    logic aw_held;
    logic [11:0] aw_addr;
    logic [2:0] aw_prot;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [11:0] aw_word;
    logic wr_go;
    logic wr_mapped;
    logic wr_ok;
    logic wr_eff;
    logic ar_go;
    logic ar_ok;
    logic [31:0] reg_rd;
    logic bus_mem_active;

    // Control and status
    logic ctrl_en;
    logic ctrl_hwtrig;
    logic [1:0] ctrl_func;
    logic [10:0] src0;
    logic [10:0] src1;
    logic [10:0] dst0;
    logic [10:0] dst1;
    logic [8:0] part;
    logic [31:0] prng_upper_limit;
    logic [31:0] prng_output_value;
    logic status_done;
    ccp_state_e state;
    logic [5:0] bit_cnt;
    logic [32:0] pr;
    logic sw_start;
    logic hw_start;
    logic go;
    logic op_mem_we;
    logic done_pulse;
    logic trig_meta;
    logic trig_sync;
    logic trig_prev;
    logic trig_rise;
    logic [2:0] seed_load;
    logic [2:0] lfsr_bit;
    logic [31:0] seed_state [3];
    logic prn_bit;
    logic [32:0] limit_incremented;
    logic [63:0] product;

    // Operand buffer, kept in an always-powered array
    logic [31:0] mem [`CCP_MEM_WORDS];

    // Handshakes are combinational; CE low stalls every channel
    assign S_AWREADY = CE && !aw_held;
    assign S_WREADY = CE && !w_held;
    assign S_ARREADY = CE && !S_RVALID;
    assign ar_go = S_ARVALID && S_ARREADY;

    assign aw_word = {aw_addr[11:2], 2'b00};
    assign wr_go = CE && aw_held && w_held && !S_BVALID;
    assign wr_mapped = is_mapped(aw_addr);
    assign wr_ok = access_ok(aw_prot[0], DEBUG_MASTER, PROT_MODE,
                             is_priv(aw_addr, part));
    assign wr_eff = wr_go && wr_mapped && wr_ok;
    assign ar_ok = access_ok(S_ARPROT[0], DEBUG_MASTER, PROT_MODE,
                             is_priv(S_ARADDR, part));

    // Any bus touch of the buffer in this cycle holds the operation off
    assign bus_mem_active = (wr_eff && aw_addr[`CCP_MEM_SEL_BIT]) ||
        (ar_go && S_ARADDR[`CCP_MEM_SEL_BIT]);

    always_ff @(posedge CLK) begin
        if (RESET) begin
            aw_held <= 1'b0;
            aw_addr <= 12'h000;
            aw_prot <= 3'h0;
        end else if (CE) begin
            if (S_AWVALID && S_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= S_AWADDR;
                aw_prot <= S_AWPROT;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (CE) begin
            if (S_WVALID && S_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_WDATA;
                w_strb <= S_WSTRB;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            S_BVALID <= 1'b0;
            S_BRESP <= `CCP_RESP_OKAY;
        end else if (CE) begin
            if (wr_go) begin
                S_BVALID <= 1'b1;
                S_BRESP <= !wr_mapped ? `CCP_RESP_DECERR
                         : !wr_ok ? `CCP_RESP_SLVERR : `CCP_RESP_OKAY;
            end else if (S_BREADY) begin
                S_BVALID <= 1'b0;
            end
        end
    end

    always_comb begin
        reg_rd = 32'h0000_0000;
        case ({S_ARADDR[11:2], 2'b00})
            `CCP_REG_CTRL: begin
                reg_rd[`CCP_CTRL_EN] = ctrl_en;
                reg_rd[`CCP_CTRL_HWTRIG] = ctrl_hwtrig;
                reg_rd[`CCP_CTRL_FUNC_LSB +: 2] = ctrl_func;
            end
            `CCP_REG_STATUS: begin
                reg_rd[`CCP_STATUS_BUSY] = BUSY;
                reg_rd[`CCP_STATUS_DONE] = status_done;
            end
            `CCP_REG_SRC0: reg_rd[10:0] = src0;
            `CCP_REG_SRC1: reg_rd[10:0] = src1;
            `CCP_REG_DST0: reg_rd[10:0] = dst0;
            `CCP_REG_DST1: reg_rd[10:0] = dst1;
            `CCP_REG_PART: reg_rd[8:0] = part;
            `CCP_REG_PRCTL: reg_rd = prng_upper_limit;
            `CCP_REG_SEED0: reg_rd = seed_state[0];
            `CCP_REG_SEED1: reg_rd = seed_state[1];
            `CCP_REG_SEED2: reg_rd = seed_state[2];
            `CCP_REG_RESULT: reg_rd = prng_output_value;
            default: reg_rd = 32'h0000_0000;
        endcase
    end

    // Refused and unmapped reads return zero data
    always_ff @(posedge CLK) begin
        if (RESET) begin
            S_RVALID <= 1'b0;
            S_RDATA <= 32'h0000_0000;
            S_RRESP <= `CCP_RESP_OKAY;
        end else if (CE) begin
            if (ar_go) begin
                S_RVALID <= 1'b1;
                if (!is_mapped(S_ARADDR)) begin
                    S_RDATA <= 32'h0000_0000;
                    S_RRESP <= `CCP_RESP_DECERR;
                end else if (!ar_ok) begin
                    S_RDATA <= 32'h0000_0000;
                    S_RRESP <= `CCP_RESP_SLVERR;
                end else begin
                    S_RDATA <= S_ARADDR[`CCP_MEM_SEL_BIT] ?
                        mem[S_ARADDR[10:2]] : reg_rd;
                    S_RRESP <= `CCP_RESP_OKAY;
                end
            end else if (S_RREADY) begin
                S_RVALID <= 1'b0;
            end
        end
    end

    // Bus writes land even mid-operation; the operation waits its turn
    always_ff @(posedge CLK) begin
        if (CE) begin
            if (wr_eff && aw_addr[`CCP_MEM_SEL_BIT]) begin
                mem[aw_addr[10:2]] <= merge(mem[aw_addr[10:2]], w_data,
                                            w_strb);
            end else if (op_mem_we) begin
                mem[dst0[10:2]] <= prng_output_value;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            {ctrl_func, ctrl_hwtrig, ctrl_en} <= `CCP_CTRL_RST;
            src0 <= `CCP_OFFS_RST;
            src1 <= `CCP_OFFS_RST;
            dst0 <= `CCP_OFFS_RST;
            dst1 <= `CCP_OFFS_RST;
            part <= `CCP_PART_RST;
            prng_upper_limit <= `CCP_LIMIT_RST;
        end else if (CE && wr_eff && w_strb[0]) begin
            case (aw_word)
                `CCP_REG_CTRL: begin
                    ctrl_en <= w_data[`CCP_CTRL_EN];
                    ctrl_hwtrig <= w_data[`CCP_CTRL_HWTRIG];
                    ctrl_func <= w_data[`CCP_CTRL_FUNC_LSB +: 2];
                end
                `CCP_REG_SRC0: src0 <= 11'(merge(32'(src0), w_data, w_strb));
                `CCP_REG_SRC1: src1 <= 11'(merge(32'(src1), w_data, w_strb));
                `CCP_REG_DST0: dst0 <= 11'(merge(32'(dst0), w_data, w_strb));
                `CCP_REG_DST1: dst1 <= 11'(merge(32'(dst1), w_data, w_strb));
                `CCP_REG_PART: part <= 9'(merge(32'(part), w_data,
                                               w_strb));
                `CCP_REG_PRCTL: prng_upper_limit <= w_data;
                default: ;
            endcase
        end
    end

    // Key/plaintext and round key/ciphertext locations for the cipher
    assign OPERANDS.source_offset_first = src0;
    assign OPERANDS.source_offset_second = src1;
    assign OPERANDS.dest_offset_first = dst0;
    assign OPERANDS.dest_offset_second = dst1;

    // Pin is asynchronous: two flops before the edge detector
    always_ff @(posedge CLK) begin
        if (RESET) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_prev <= 1'b0;
        end else if (CE) begin
            trig_meta <= TRIG_IN;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
        end
    end

    assign trig_rise = trig_sync && !trig_prev;
    assign hw_start = trig_rise && ctrl_hwtrig;
    assign sw_start = wr_eff && aw_word == `CCP_REG_CTRL && w_strb[0] &&
        w_data[`CCP_CTRL_START];
    // Start uses the function already configured, never the same write's
    assign go = (sw_start || hw_start) && ctrl_en &&
        ctrl_func == `CCP_FUNC_PRNG && state == CCP_IDLE;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_lfsr
            assign seed_load[g] = wr_eff &&
                aw_word == `CCP_REG_SEED0 + 12'(4 * g);
            ccp_lfsr #(.W(LEN[g]), .TAPS(TAP[g])) u_lfsr (
                .clk(CLK),
                .reset(RESET),
                .ce(CE),
                .shift(state == CCP_GATHER),
                .load(seed_load[g]),
                .load_value(merge(seed_state[g], w_data, w_strb)),
                .state(seed_state[g]),
                .out_bit(lfsr_bit[g])
            );
        end
    endgenerate

    assign prn_bit = ^lfsr_bit;
    assign limit_incremented = {1'b0, prng_upper_limit} + 33'h0_0000_0001;
    assign product = ({31'h0, limit_incremented} * {32'h0, pr[32:1]}) +
        (pr[0] ? {32'h0, prng_upper_limit} : 64'h0);
    assign op_mem_we = CE && state == CCP_STORE && !bus_mem_active;
    assign done_pulse = op_mem_we;
    assign BUSY = state != CCP_IDLE;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            state <= CCP_IDLE;
            bit_cnt <= 6'd0;
            pr <= 33'h0;
            prng_output_value <= 32'h0000_0000;
        end else if (CE) begin
            case (state)
                CCP_IDLE: begin
                    if (go) begin
                        state <= CCP_GATHER;
                        bit_cnt <= 6'd0;
                    end
                end
                CCP_GATHER: begin
                    pr <= {pr[31:0], prn_bit};
                    bit_cnt <= bit_cnt + 6'd1;
                    if (bit_cnt == `CCP_PRNG_BITS - 6'd1) begin
                        state <= CCP_COMPUTE;
                    end
                end
                CCP_COMPUTE: begin
                    prng_output_value <= product[63:32];
                    state <= CCP_STORE;
                end
                CCP_STORE: begin
                    if (!bus_mem_active) begin
                        state <= CCP_IDLE;
                    end
                end
                default: state <= CCP_IDLE;
            endcase
        end
    end

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge CLK) begin
        if (RESET) begin
            status_done <= 1'b0;
            TRIG_OUT <= 1'b0;
        end else if (CE) begin
            TRIG_OUT <= done_pulse;
            if (done_pulse) begin
                status_done <= 1'b1;
            end else if (wr_eff && aw_word == `CCP_REG_STATUS && w_strb[0] &&
                         w_data[`CCP_STATUS_DONE]) begin
                status_done <= 1'b0;
            end
        end
    end

    single_op_a: assert property (@(posedge CLK) disable iff (RESET)
        (CE && state == CCP_GATHER && (sw_start || hw_start))
        |=> state != CCP_IDLE && bit_cnt != 6'd0)
        else $error("start accepted while busy");
    hw_start_a: assert property (@(posedge CLK) disable iff (RESET)
        (CE && trig_rise && ctrl_hwtrig && ctrl_en && !BUSY &&
         ctrl_func == `CCP_FUNC_PRNG) |=> state == CCP_GATHER)
        else $error("trigger edge did not start");
    done_pulse_a: assert property (@(posedge CLK) disable iff (RESET)
        TRIG_OUT |=> !TRIG_OUT)
        else $error("output trigger longer than one cycle");
    done_flag_a: assert property (@(posedge CLK) disable iff (RESET)
        (CE && state == CCP_STORE && !bus_mem_active)
        |=> status_done && !BUSY && TRIG_OUT)
        else $error("completion not reported");
    bus_priority_a: assert property (@(posedge CLK) disable iff (RESET)
        (wr_eff && aw_addr[`CCP_MEM_SEL_BIT] && w_strb == 4'hf) |=>
        mem[$past(aw_addr[10:2])] == $past(w_data))
        else $error("operation took buffer from bus");
    user_refused_a: assert property (@(posedge CLK) disable iff (RESET)
        (wr_go && wr_mapped && !aw_prot[0] && !DEBUG_MASTER &&
         PROT_MODE == CCP_PM_PROTECTED && is_priv(aw_addr, part))
        |=> S_BVALID && S_BRESP == `CCP_RESP_SLVERR)
        else $error("user write to privileged space not refused");
    xor_bit_a: assert property (@(posedge CLK) disable iff (RESET)
        (CE && state == CCP_GATHER && !(|seed_load))
        |=> pr[0] == ($past(seed_state[0][0]) ^ $past(seed_state[1][0]) ^
                      $past(seed_state[2][0])))
        else $error("random bit not xor of registers");
    result_calc_a: assert property (@(posedge CLK) disable iff (RESET)
        (CE && state == CCP_COMPUTE)
        |=> prng_output_value == $past(product[63:32]) && state == CCP_STORE)
        else $error("result not upper product half");
    seed_load_a: assert property (@(posedge CLK) disable iff (RESET)
        (CE && seed_load[0] && w_strb == 4'hf)
        |=> seed_state[0] == $past(w_data))
        else $error("seed not loaded");
endmodule // ccp_core

// ---- test/ccp_bus_master.sv ----
// Register bus master standing in for the processor
module ccp_bus_master (
    // Clock
    input wire logic CLK,
    // Write channels
    output logic S_AWVALID,
    input wire logic S_AWREADY,
    output logic [11:0] S_AWADDR,
    output logic [2:0] S_AWPROT,
    output logic S_WVALID,
    input wire logic S_WREADY,
    output logic [31:0] S_WDATA,
    output logic [3:0] S_WSTRB,
    input wire logic S_BVALID,
    output logic S_BREADY,
    input wire logic [1:0] S_BRESP,
    // Read channels
    output logic S_ARVALID,
    input wire logic S_ARREADY,
    output logic [11:0] S_ARADDR,
    output logic [2:0] S_ARPROT,
    input wire logic S_RVALID,
    output logic S_RREADY,
    input wire logic [31:0] S_RDATA,
    input wire logic [1:0] S_RRESP
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {S_AWVALID, S_WVALID, S_ARVALID} = '0;
        {S_AWADDR, S_ARADDR, S_AWPROT, S_ARPROT, S_WDATA} = '0;
        // Answers are never refused, so ready stays up
        {S_BREADY, S_RREADY} = 2'h3;
        S_WSTRB = 4'hf;
    end
    // Handshakes judged at the falling edge, where the inputs have settled
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
            input logic [2:0] p, output logic [1:0] r);
        logic ah, wh, b;
        b = 1'h0;
        @(posedge CLK);
        S_AWADDR <= a;
        S_AWPROT <= p;
        S_WDATA <= d;
        S_AWVALID <= 1'h1;
        S_WVALID <= 1'h1;
        while (!b) begin
            @(negedge CLK);
            ah = S_AWVALID && S_AWREADY;
            wh = S_WVALID && S_WREADY;
            b = S_BVALID;
            r = S_BRESP;
            @(posedge CLK);
            if (ah) S_AWVALID <= 1'h0;
            if (wh) S_WVALID <= 1'h0;
        end
        // Released lines must not keep showing the old value
        S_AWADDR <= ~a;
        S_WDATA <= ~d;
    endtask
    task automatic rd(input logic [11:0] a, input logic [2:0] p,
            output logic [31:0] d, output logic [1:0] r);
        logic ah, v;
        v = 1'h0;
        @(posedge CLK);
        S_ARADDR <= a;
        S_ARPROT <= p;
        S_ARVALID <= 1'h1;
        while (!v) begin
            @(negedge CLK);
            ah = S_ARVALID && S_ARREADY;
            v = S_RVALID;
            d = S_RDATA;
            r = S_RRESP;
            @(posedge CLK);
            if (ah) S_ARVALID <= 1'h0;
        end
        S_ARADDR <= ~a;
    endtask
endmodule // ccp_bus_master

// ---- test/ccp_core_tb.sv ----
// Self-checking bench for the crypto core and its generator
`include "ccp_map.svh"
module ccp_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ccp_pkg::*;
    logic CLK, RESET, CE, TRIG_IN, DEBUG_MASTER, TRIG_OUT, BUSY;
    logic S_AWVALID, S_AWREADY, S_WVALID, S_WREADY, S_BVALID, S_BREADY;
    logic S_ARVALID, S_ARREADY, S_RVALID, S_RREADY;
    logic [11:0] S_AWADDR, S_ARADDR;
    logic [2:0] S_AWPROT, S_ARPROT, pv;
    logic [31:0] S_WDATA, S_RDATA, v;
    logic [3:0] S_WSTRB;
    logic [1:0] S_BRESP, S_RRESP, rr;
    ccp_pmode_e PROT_MODE;
    ccp_opnd_s OPERANDS;
    int error_cnt = 0;
    int n_tests = 0;
    int pulses = 0;
    int p0;
    ccp_core dut_u (.*);
    ccp_bus_master m_u (.*);
    initial begin
        CLK = 1'h0;
        forever #20 CLK = ~CLK;
    end
    always @(posedge CLK)
        if (TRIG_OUT === 1'h1) pulses <= pulses + 1;
    task automatic chk(input string n, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic w(input logic [11:0] a, input logic [31:0] d,
            input logic [1:0] e = 2'h0);
        m_u.wr(a, d, pv, rr);
        chk("bresp", 32'(rr), 32'(e));
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] ed,
            input logic [1:0] e = 2'h0);
        m_u.rd(a, pv, v, rr);
        chk("rresp", 32'(rr), 32'(e));
        chk("rdata", v, ed);
    endtask
    // Bounded only by the watchdog; the done pulse rises as busy drops and is counted an edge later
    task automatic finish_op();
        while (BUSY !== 1'h0) @(posedge CLK);
        repeat (2) @(posedge CLK);
    endtask
    initial begin
        repeat (5000) @(posedge CLK);
        error_cnt++;
        print_verdict();
    end
    initial begin
        {RESET, CE, pv} = 5'h19;
        {TRIG_IN, DEBUG_MASTER} = 2'h0;
        PROT_MODE = CCP_PM_FRESH;
        repeat (16) @(posedge CLK);
        RESET <= 1'h0;
        rc(`CCP_REG_STATUS, 0);
        rc(12'h01c, 0, `CCP_RESP_DECERR);
        for (int i = 0; i < 3; i++) begin
            v = 32'h1357_9bdf >> (2 * i);
            w(`CCP_REG_SEED0 + 12'(4 * i), v);
            rc(`CCP_REG_SEED0 + 12'(4 * i), v);
        end
        w(`CCP_REG_SRC0, 32'h123);
        chk("src0", 32'(OPERANDS.source_offset_first), 32'h123);
        w(`CCP_REG_DST0, 32'h100);
        chk("dst0", 32'(OPERANDS.dest_offset_first), 32'h100);
        w(`CCP_REG_SRC1, 32'h2a4);
        chk("src1", 32'(OPERANDS.source_offset_second), 32'h2a4);
        w(`CCP_REG_DST1, 32'h7fc);
        chk("dst1", 32'(OPERANDS.dest_offset_second), 32'h7fc);
        w(`CCP_REG_PRCTL, 5);
        w(`CCP_REG_CTRL, 32'h11);
        p0 = pulses;
        w(`CCP_REG_CTRL, 32'h13);
        chk("busy", 32'(BUSY), 1);
        w(12'h804, 32'hcafe_f00d);
        w(`CCP_REG_CTRL, 32'h13);
        finish_op();
        chk("pulses", 32'(pulses - p0), 1);
        rc(`CCP_REG_STATUS, 2);
        rc(12'h804, 32'hcafe_f00d);
        m_u.rd(`CCP_REG_RESULT, pv, v, rr);
        chk("range", 32'(v <= 5), 1);
        rc(12'h900, v);
        m_u.rd(`CCP_REG_SEED0, pv, v, rr);
        chk("moved", 32'(v !== 32'h1357_9bdf), 1);
        w(`CCP_REG_PRCTL, 0);
        w(`CCP_REG_STATUS, 2);
        rc(`CCP_REG_STATUS, 0);
        w(`CCP_REG_CTRL, 32'h15);
        p0 = pulses;
        TRIG_IN <= 1'h1;
        repeat (6) @(posedge CLK);
        chk("busy", 32'(BUSY), 1);
        TRIG_IN <= 1'h0;
        finish_op();
        chk("pulses", 32'(pulses - p0), 1);
        rc(`CCP_REG_RESULT, 0);
        for (int i = 0; i < 5; i++) begin
            PROT_MODE <= ccp_pmode_e'(5'h1 << i);
            DEBUG_MASTER <= 1'h1;
            rc(`CCP_REG_CTRL, i < 2 ? 32'h15 : 0, i < 2 ? 0 : 2);
            DEBUG_MASTER <= 1'h0;
            pv = 3'h0;
            w(`CCP_REG_PART, 0, i % 4 == 0 ? 0 : 2);
            pv = 3'h1;
            w(`CCP_REG_PART, 0);
        end
        PROT_MODE <= CCP_PM_OPEN;
        w(`CCP_REG_PART, 8);
        pv = 3'h0;
        rc(12'h800, 0, `CCP_RESP_SLVERR);
        w(12'h820, 32'h5a5a_a5a5);
        rc(12'h820, 32'h5a5a_a5a5);
        print_verdict();
    end
endmodule // ccp_core_tb
